// file: common/stage_ctrl_defines.svh
// Purpose: Timing and counter width constants for the power stage controller
// Assumes: System clock of 10 MHz
// Notes: Counts derive from times in ns
`ifndef STAGE_CTRL_DEFINES_SVH
`define STAGE_CTRL_DEFINES_SVH
`define CLK_PERIOD_NS 100
`define POR_DELAY_NS 15000
`define EXIT_LATENCY_NS 15000
`define HOLDOFF_MAX_NS 250
`define MAX_SW_FREQ_KHZ 1500
`define MIN_PERIOD_NS (1000000 / `MAX_SW_FREQ_KHZ)
`define POR_CYCLES ((`POR_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXIT_CYCLES ((`EXIT_LATENCY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLDOFF_CYCLES ((`HOLDOFF_MAX_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MIN_PERIOD_CYCLES ((`MIN_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 8
`endif

// file: common/stage_ctrl_pkg.sv
// Purpose: Types for the power stage controller
// Assumes: Nothing
// Notes: Pin level encodings
package stage_ctrl_pkg;
  typedef enum logic [1:0] {
    PIN_LOW,
    PIN_HIGH,
    PIN_MID
  } pin_level_t;
  typedef enum logic [2:0] {
    ST_OFF,
    ST_STARTUP,
    ST_RUN,
    ST_SHUTDOWN,
    ST_WAKE
  } ctrl_state_t;
endpackage

// file: src/pwm_pacer.sv
// Purpose: Limits pulse-width output edges to the maximum switching rate
// Assumes: Request from logic on the same clock
// Notes: A new rising edge waits until a full minimum period has passed
`timescale 1ns/1ps
`include "stage_ctrl_defines.svh"
module pwm_pacer #(
  parameter int PERIOD_CYCLES = `MIN_PERIOD_CYCLES
) (
  input wire logic clk,    // System clock
  input wire logic rst_n,  // Synchronous reset
  input wire logic ce,     // Clock enable
  input wire logic req,    // Requested pulse level
  output logic pwm_level   // Paced pulse level
);
  logic [`CNT_W-1:0] since_rise;
  wire logic period_done = (since_rise >= (`CNT_W)'(PERIOD_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwm_level <= 1'b0;
    end else if (ce) begin
      if (!pwm_level && req && period_done) begin
        pwm_level <= 1'b1;
      end else if (pwm_level && !req) begin
        pwm_level <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      since_rise <= '1;
    end else if (ce) begin
      if (!pwm_level && req && period_done) begin
        since_rise <= '0;
      end else if (!period_done) begin
        since_rise <= since_rise + 1'b1;
      end
    end
  end
endmodule

// file: src/stage_controller.sv
// Purpose: Controller that drives a power stage's pulse-width and mode pins
// Assumes: Stage inputs are three-level pins built from drive and enable
// Notes: Enable of each pin is low while the pin is driven
`timescale 1ns/1ps
`include "stage_ctrl_defines.svh"
// Behaviour
// - During startup the pulse pin is left floating in the mid window.
// - After leaving mode-pin float, no switching is expected before latency.
// - Mode pin is driven directly by this controller.
// - Pulse pin never switches faster than the maximum rate.
// - All supplies, pulse and mode signals must be present to switch.
module stage_controller #(
  parameter int POR_CYCLES = `POR_CYCLES,
  parameter int EXIT_CYCLES = `EXIT_CYCLES,
  parameter int HOLDOFF_CYCLES = `HOLDOFF_CYCLES
) (
  input wire logic CLK_SYS,         // 10 MHz system clock
  input wire logic RST_N,           // Synchronous reset, active low
  input wire logic CE,              // Clock enable
  input wire logic SUPPLY_GOOD,     // Logic, gate supply and rail present
  input wire logic RUN_REQ,         // Request switching operation
  input wire logic SLEEP_REQ,       // Request low-power shutdown
  input wire logic PHASE_OFF,       // Shed this phase: float pulse pin
  input wire logic DIODE_EMU,       // Request diode emulation
  input wire logic DUTY_REQ,        // Requested pulse level
  output logic PWM_OUT,             // Pulse pin drive value
  output logic PWM_OE_N,            // Pulse pin enable, low drives
  output logic MODE_OUT,            // Mode pin drive value
  output logic MODE_OE_N,           // Mode pin enable, low drives
  output logic STAGE_READY,         // Stage may be switched
  output logic STAGE_OFF_DONE       // Gates known off after hold-off
);
  stage_ctrl_pkg::ctrl_state_t state;
  stage_ctrl_pkg::ctrl_state_t next_state;
  logic [15:0] timer;
  logic [15:0] off_timer;
  logic supply_s1;
  logic supply_s2;
  logic paced_pwm;
  logic float_pwm;

  // Supply status comes from a pin outside the clock domain
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      supply_s1 <= 1'b0;
      supply_s2 <= 1'b0;
    end else if (CE) begin
      supply_s1 <= SUPPLY_GOOD;
      supply_s2 <= supply_s1;
    end
  end

  pwm_pacer pwm_pacer_inst (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .ce(CE),
    .req(DUTY_REQ && state == stage_ctrl_pkg::ST_RUN && !PHASE_OFF),
    .pwm_level(paced_pwm)
  );

  always_comb begin
    next_state = state;
    case (state)
      stage_ctrl_pkg::ST_OFF: begin
        if (supply_s2 && RUN_REQ) begin
          next_state = stage_ctrl_pkg::ST_STARTUP;
        end
      end
      stage_ctrl_pkg::ST_STARTUP: begin
        if (timer >= 16'(POR_CYCLES - 1)) begin
          next_state = stage_ctrl_pkg::ST_RUN;
        end
      end
      stage_ctrl_pkg::ST_RUN: begin
        if (SLEEP_REQ) begin
          next_state = stage_ctrl_pkg::ST_SHUTDOWN;
        end
      end
      stage_ctrl_pkg::ST_SHUTDOWN: begin
        if (!SLEEP_REQ) begin
          next_state = stage_ctrl_pkg::ST_WAKE;
        end
      end
      stage_ctrl_pkg::ST_WAKE: begin
        // Mode pin is released one edge after entry, so count a full latency
        if (timer >= 16'(EXIT_CYCLES)) begin
          next_state = stage_ctrl_pkg::ST_RUN;
        end
      end
      default: next_state = stage_ctrl_pkg::ST_OFF;
    endcase
    if (!supply_s2 || !RUN_REQ) begin
      next_state = stage_ctrl_pkg::ST_OFF;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state <= stage_ctrl_pkg::ST_OFF;
    end else if (CE) begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      timer <= '0;
    end else if (CE) begin
      if (next_state != state) begin
        timer <= '0;
      end else if (timer != 16'hFFFF) begin
        timer <= timer + 16'h0001;
      end
    end
  end

  // Pulse pin floats until running and while the phase is shed
  assign float_pwm = (state != stage_ctrl_pkg::ST_RUN) || PHASE_OFF;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      off_timer <= '0;
      STAGE_OFF_DONE <= 1'b1;
    end else if (CE) begin
      if (!float_pwm) begin
        off_timer <= '0;
        STAGE_OFF_DONE <= 1'b0;
      end else if (off_timer >= 16'(HOLDOFF_CYCLES)) begin
        STAGE_OFF_DONE <= 1'b1;
      end else begin
        off_timer <= off_timer + 16'h0001;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      PWM_OUT <= 1'b0;
      PWM_OE_N <= 1'b1;
    end else if (CE) begin
      PWM_OUT <= paced_pwm;
      PWM_OE_N <= float_pwm;
    end
  end

  // Mode pin: high forces continuous, low allows emulation, float sleeps
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      MODE_OUT <= 1'b1;
      MODE_OE_N <= 1'b0;
    end else if (CE) begin
      MODE_OUT <= !DIODE_EMU;
      MODE_OE_N <= (state == stage_ctrl_pkg::ST_SHUTDOWN);
    end
  end

  assign STAGE_READY = (state == stage_ctrl_pkg::ST_RUN);
endmodule

// file: tb/stage_controller_properties.sv
// Purpose: Port checks for stage_controller
// Assumes: POR and exit counts of 5, hold-off of 3
// Notes: Watches a subset of the top ports
`timescale 1ns/1ps
module stage_checks (input wire logic CLK_SYS, RST_N, CE, RUN_REQ, SLEEP_REQ, DIODE_EMU,
  PWM_OUT, PWM_OE_N, MODE_OUT, MODE_OE_N, STAGE_READY, STAGE_OFF_DONE);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  sequence s_idle2; !RUN_REQ [*2]; endsequence
  sequence s_float5; PWM_OE_N [*5]; endsequence
  property p_mode; CE |=> MODE_OUT == !$past(DIODE_EMU); endproperty
  property p_pace; $rose(PWM_OUT) |=> !$rose(PWM_OUT) [*6]; endproperty
  property p_sleep; STAGE_READY && SLEEP_REQ && RUN_REQ && CE |-> ##2 MODE_OE_N; endproperty
  property p_offready; MODE_OE_N |-> !STAGE_READY; endproperty
  property p_wake; $fell(MODE_OE_N) |-> !STAGE_READY [*5]; endproperty
  property p_float; !STAGE_READY && !$past(STAGE_READY) |-> PWM_OE_N; endproperty
  property p_off; s_idle2 |=> PWM_OE_N; endproperty
  property p_hold; s_float5 |-> STAGE_OFF_DONE; endproperty
  property p_drive; !PWM_OE_N |-> !STAGE_OFF_DONE; endproperty
  a_mode: assert property (p_mode) else $error("mode lags");
  a_pace: assert property (p_pace) else $error("pulse too fast");
  a_sleep: assert property (p_sleep) else $error("mode not floated");
  a_offready: assert property (p_offready) else $error("ready in shutdown");
  a_wake: assert property (p_wake) else $error("ready too soon");
  a_float: assert property (p_float) else $error("pulse driven early");
  a_off: assert property (p_off) else $error("pulse driven when off");
  a_hold: assert property (p_hold) else $error("off flag missing");
  a_drive: assert property (p_drive) else $error("off flag while driving");
endmodule
bind stage_controller stage_checks stage_checks_inst (.*);

// file: tb/stage_model.sv
// Purpose: Behavioural power stage gate logic
// Assumes: Pin floated when enable is high
// Notes: Startup and wake counts of 5 cycles
`timescale 1ns/1ps
module stage_model (input wire logic clk, vcc_ok, pwm_d, pwm_oe_n, mode_d, mode_oe_n, il_pos,
  output logic high_side_gate = 0, low_side_gate = 0, en = 0);
  int cnt = 0;
  int mid = 0;
  always @(posedge clk) begin
    if (!vcc_ok || mode_oe_n) begin
      cnt <= 0;
      en <= 0;
    end else if (cnt < 5) cnt <= cnt + 1;
    else en <= 1;
    mid <= pwm_oe_n ? mid + 1 : 0;
    if (!en || !pwm_oe_n || mid >= 2) begin
      high_side_gate <= en && !pwm_oe_n && pwm_d;
      low_side_gate <= en && !pwm_oe_n && !pwm_d && (mode_d || il_pos);
    end
  end
endmodule

// file: tb/tb_stage_controller.sv
// Purpose: Bench for stage_controller with stage model
// Assumes: Inputs change at falling edge
// Notes: Short POR and wake counts
`timescale 1ns/1ps
module tb_stage_controller;
  logic clk = 0, rst_n = 0, ce = 1, sup = 0, run = 0, slp = 0, shed = 0, de = 0, duty = 0;
  logic il = 0;
  logic pwm, pwm_oe_n, mode, mode_oe_n, rdy, off_done, hg, lg, en, prev;
  int fail_count = 0, samples_checked = 0, n;
  initial forever #50 clk = ~clk;
  stage_controller #(.POR_CYCLES(5), .EXIT_CYCLES(5), .HOLDOFF_CYCLES(3)) stage_controller_inst (
    .CLK_SYS(clk), .RST_N(rst_n), .CE(ce), .SUPPLY_GOOD(sup), .RUN_REQ(run),
    .SLEEP_REQ(slp), .PHASE_OFF(shed), .DIODE_EMU(de), .DUTY_REQ(duty), .PWM_OUT(pwm),
    .PWM_OE_N(pwm_oe_n), .MODE_OUT(mode), .MODE_OE_N(mode_oe_n), .STAGE_READY(rdy),
    .STAGE_OFF_DONE(off_done));
  stage_model stage_model_inst (.clk(clk), .vcc_ok(sup), .pwm_d(pwm), .pwm_oe_n(pwm_oe_n),
    .mode_d(mode), .mode_oe_n(mode_oe_n), .il_pos(il), .high_side_gate(hg),
    .low_side_gate(lg), .en(en));
  task check(input logic seen, input logic exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task step(input int k);
    repeat (k) @(negedge clk);
  endtask
  task report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task t_start;
    run = 1;
    step(10);
    check(rdy, 0);
    check(hg | lg | en, 0);
    sup = 1;
    for (n = 0; n < 40 && !rdy; n++) begin
      check(pwm_oe_n, 1);
      step(1);
    end
    check(n >= 5 && n < 40, 1);
    $display("startup done");
  endtask
  task t_switch;
    step(2);
    check(pwm_oe_n, 0);
    ce = 0;
    duty = 1;
    step(3);
    check(pwm, 0);
    ce = 1;
    step(3);
    check(hg && !lg, 1);
    duty = 0;
    step(3);
    check(lg && !hg, 1);
    n = 0;
    for (int i = 0; i < 28; i++) begin
      prev = pwm;
      duty = !duty;
      step(1);
      n += (pwm && !prev);
    end
    check(n >= 2 && n <= 4, 1);
    duty = 0;
    de = 1;
    il = 1;
    step(3);
    check(mode, 0);
    check(lg, 1);
    il = 0;
    step(1);
    check(lg, 0);
    de = 0;
    step(2);
    check(lg, 1);
    $display("switching done");
  endtask
  task t_shed;
    shed = 1;
    step(8);
    check(pwm_oe_n && off_done && en, 1);
    check(hg | lg, 0);
    shed = 0;
    step(3);
    $display("shed done");
  endtask
  task t_sleep;
    slp = 1;
    step(4);
    check(mode_oe_n, 1);
    check(rdy | en | hg | lg, 0);
    slp = 0;
    for (n = 0; n < 40 && !rdy; n++) step(1);
    check(n >= 7 && n < 40, 1);
    run = 0;
    step(3);
    check(rdy | !pwm_oe_n, 0);
    $display("sleep done");
  endtask
  initial begin
    #20000;
    fail_count++;
    report_and_stop;
  end
  initial begin
    step(5);
    check({pwm, pwm_oe_n, mode, mode_oe_n, rdy, off_done} === 6'h19, 1);
    rst_n = 1;
    t_start;
    t_switch;
    t_shed;
    t_sleep;
    report_and_stop;
  end
endmodule
